/* rtl/mtnhs_pkg.sv */
// Shared constants of the motion axis handshake flag block
package mtnhs_pkg;
	localparam int NAXIS = 8;
	localparam int NWHEEL = 3;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_READY_WORD = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_START_ACC = 8'h0c;
	localparam logic [7:0] OFS_AXIS_CMD = 8'h10;
	localparam logic [7:0] OFS_FINISH = 8'h14;
	localparam logic [7:0] OFS_START_ERR = 8'h18;
	// Control register fields
	localparam int CTRL_ALT_MODE = 0;
	localparam int CTRL_SPEED_SW = 1;
	localparam int CTRL_READY_RELAY = 2;
	// Status register fields
	localparam int ST_HOST_READY = 0;
	localparam int ST_PROC_READY = 1;
	localparam int ST_TEST_MODE = 2;
	localparam int ST_SYS_ERR = 3;
	localparam int ST_EDGE_ERR = 4;
	localparam int ST_PENDING = 5;
	localparam int ST_MOTION_EN = 6;
	// Axis command register field bases
	localparam int CMD_GAIN = 0;
	localparam int CMD_GAIN_ALT = 8;
	localparam int CMD_PID = 16;
	localparam int CMD_LOOP = 24;
	// Finish register field bases
	localparam int FIN_WAIT = 0;
	localparam int FIN_CODE = 8;
	// Reset values
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [15:0] RST_READY_WORD = 16'h0000;
	localparam logic [31:0] RST_AXIS_CMD = 32'h0000_0000;
	localparam logic [7:0] RST_FINISH = 8'h00;
	// Gain selection codes sent to the amplifier
	localparam logic [1:0] GAIN_BASE = 2'h0;
	localparam logic [1:0] GAIN_PRIMARY = 2'h1;
	localparam logic [1:0] GAIN_ALT = 2'h2;
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
endpackage

/* rtl/mtnhs_axis.sv */
// Per-axis servo option and start-accepted flag logic
`timescale 1ns/100ps
module mtnhs_axis (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic gain_change_cmd,
	input wire logic gain_change_alt_cmd,
	input wire logic pid_select_cmd,
	input wire logic closed_loop_select_cmd,
	input wire logic amp_started,
	input wire logic amp_closed_capable,
	input wire logic amp_link_ok,
	input wire logic amp_ctrl_power,
	input wire logic finish_wait,
	input wire logic finish_ack_in,
	input wire logic code_request,
	input wire logic motion_enable,
	input wire logic start_allowed,
	input wire logic start_req,
	input wire logic pos_complete,
	input wire logic stop_midway,
	input wire logic speed_zero_stop,
	input wire logic jog_fwd_cmd,
	input wire logic jog_rev_cmd,
	input wire logic axis_stopped,
	input wire logic handwheel_on,
	input wire logic position_change_instr,
	input wire logic force_set,
	output logic [1:0] amp_gain_sel,
	output logic amp_pid,
	output logic amp_closed_loop,
	output logic code_output_flag,
	output logic start_accepted_flag,
	output logic start_accept_err
);
	logic prog_busy;
	logic jog_busy;
	logic forced;
	logic start_ok;
	logic loop_prev;

	// Gain and PI/PID follow the commands each cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			amp_gain_sel <= mtnhs_pkg::GAIN_BASE;
			amp_pid <= 1'b0;
		end
		else
		begin
			if (gain_change_alt_cmd)
				amp_gain_sel <= mtnhs_pkg::GAIN_ALT; // RULE1
			else if (gain_change_cmd)
				amp_gain_sel <= mtnhs_pkg::GAIN_PRIMARY;
			else
				amp_gain_sel <= mtnhs_pkg::GAIN_BASE;
			amp_pid <= pid_select_cmd; // RULE2
		end
	end

	// Loop select acts on command edges; link or power loss wins
	always_ff @(posedge core_clk)
	begin
		loop_prev <= rst_n && closed_loop_select_cmd;
		if (!rst_n)
			amp_closed_loop <= 1'b0; // RULE5
		else if (!amp_link_ok || !amp_ctrl_power)
			amp_closed_loop <= 1'b0; // RULE5
		else if (amp_started && amp_closed_capable && closed_loop_select_cmd != loop_prev) // RULE4
			amp_closed_loop <= closed_loop_select_cmd; // RULE3
	end

	// Code output only exists under finish-wait acceleration
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !finish_wait)
			code_output_flag <= 1'b0; // RULE6
		else if (code_request)
			code_output_flag <= 1'b1; // RULE6
		else if (finish_ack_in)
			code_output_flag <= 1'b0; // RULE6
	end

	assign start_ok = start_req && start_allowed && !forced;

	// Program start and jog each own a share of the flag
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			prog_busy <= 1'b0;
			jog_busy <= 1'b0;
		end
		else
		begin
			if (start_ok)
				prog_busy <= 1'b1; // RULE15
			else if (pos_complete || (stop_midway && !speed_zero_stop))
				prog_busy <= 1'b0; // RULE15 RULE16
			if ((jog_fwd_cmd || jog_rev_cmd) && motion_enable)
				jog_busy <= 1'b1; // RULE17
			else if (!jog_fwd_cmd && !jog_rev_cmd && axis_stopped)
				jog_busy <= 1'b0; // RULE17
		end
	end

	// A flag forced on while idle poisons the next start
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			forced <= 1'b0;
			start_accept_err <= 1'b0;
		end
		else
		begin
			if (start_req && forced)
			begin
				forced <= 1'b0;
				start_accept_err <= 1'b1; // RULE20
			end
			else if (force_set && !start_accepted_flag)
				forced <= 1'b1;
		end
	end

	// Handwheel and position change hold the flag level-wise
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			start_accepted_flag <= 1'b0;
		else
			start_accepted_flag <= (start_ok || prog_busy || jog_busy || forced
				|| handwheel_on || position_change_instr); // RULE18 RULE19
	end

	gain_prio_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		gain_change_alt_cmd |=> amp_gain_sel == mtnhs_pkg::GAIN_ALT) // RULE1
		else $error("alternate gain not applied");
	loop_fallback_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!amp_link_ok |=> !amp_closed_loop) // RULE5
		else $error("closed loop kept after link loss");
	loop_frozen_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!amp_started && amp_link_ok && amp_ctrl_power) |=> $stable(amp_closed_loop)) // RULE4
		else $error("loop changed before amplifier start");
	code_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!finish_wait |=> !code_output_flag) // RULE6
		else $error("code output without finish wait");
	forced_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(start_req && forced) |=> start_accept_err && !prog_busy) // RULE20
		else $error("forced flag start not refused");
	wheel_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		handwheel_on |=> start_accepted_flag) // RULE18
		else $error("start flag dropped under handwheel");
endmodule

/* rtl/mtnhs_top.sv */
// Host ready handshake, common flags and AHB-Lite register slave
// How it works
// RULE1 - Secondary gain change wins when both gain commands are asserted.
// RULE2 - PID control while PI/PID select asserted, PI control otherwise.
// RULE3 - Capable amplifier: fully closed loop when selected, else semi closed.
// RULE4 - Loop-select changes are ignored until the amplifier has started.
// RULE5 - Reset, link break or amplifier power loss forces semi closed loop.
// RULE6 - Finish acknowledge and code output work only under finish-wait acceleration.
// RULE7 - No positioning, homing, jog or handwheel without host ready or in test.
// RULE8 - Tool parameter writes accepted only while host ready is off.
// RULE9 - Host ready rise clears codes, sets ready-complete, starts auto program.
// RULE10 - Host ready rise with a moving axis flags error, skips processing.
// RULE11 - Host ready rise in test mode defers processing until test ends.
// RULE12 - Host ready fall clears ready-complete, stops axes, halts program, outputs off.
// RULE13 - Default option: ready follows run/stop switch and power-up in run.
// RULE14 - Alternative: in run, ready follows edges of ready word bit or relay.
// RULE15 - Start flag set at program start, cleared at completion or midway stop.
// RULE16 - Start flag stays set when stopped by a speed change to zero.
// RULE17 - Start flag set during jog, cleared when jog released and axis stopped.
// RULE18 - Start flag held while the handwheel enable of the axis is on.
// RULE19 - Start flag set during a position change, cleared on its completion.
// RULE20 - Flag forced on while idle gives start-accept error at next start.
// RULE21 - Speed switch option set before start applies speed from first pass point.
// RULE22 - System setting error refuses starts until reset or power cycle.
// RULE23 - Host ready edges found by comparing with last cycle's value.
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
module mtnhs_top (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic run_switch,
	input wire logic test_mode_flag,
	input wire logic sys_setting_fault,
	input wire logic tool_write_req,
	input wire logic position_change_instr_done,
	input wire logic [7:0] start_req,
	input wire logic [7:0] pos_complete,
	input wire logic [7:0] stop_midway,
	input wire logic [7:0] speed_zero_stop,
	input wire logic [7:0] axis_moving,
	input wire logic [7:0] jog_fwd_cmd,
	input wire logic [7:0] jog_rev_cmd,
	input wire logic [2:0] handwheel_enable,
	input wire logic [7:0] position_change_instr,
	input wire logic [7:0] amp_started,
	input wire logic [7:0] amp_closed_capable,
	input wire logic [7:0] amp_link_ok,
	input wire logic [7:0] amp_ctrl_power,
	input wire logic [7:0] finish_ack_in,
	input wire logic [7:0] code_request,
	output logic host_ready_flag,
	output logic proc_ready_complete,
	output logic ready_edge_error,
	output logic motion_enable,
	output logic clear_code_storage,
	output logic program_start,
	output logic program_halt,
	output logic decel_stop_all,
	output logic real_output_points_off,
	output logic tool_write_ack,
	output logic tool_write_nak,
	output logic system_setting_error_flag,
	output logic speed_first_pass,
	output logic [7:0] start_accepted_flag,
	output logic [7:0] start_accept_err,
	output logic [15:0] amp_gain_sel,
	output logic [7:0] amp_pid,
	output logic [7:0] amp_closed_loop,
	output logic [7:0] code_output_flag
);
	logic [31:0] ctrl;
	logic [15:0] ready_setting_word;
	logic [31:0] axis_cmd;
	logic [7:0] finish_wait;
	logic [7:0] force_set;
	logic [7:0] dph_addr;
	logic dph_write;
	logic [31:0] next_rdata;
	logic host_prev;
	logic run_prev;
	logic word_prev;
	logic relay_prev;
	logic pending;
	logic host_rise;
	logic host_fall;
	logic do_rise;
	logic start_allowed;
	logic [7:0] hw_axis;

	// Single-cycle slave: never stalls, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = mtnhs_pkg::HRESP_OKAY;

	// Capture the address phase of a valid transfer
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			dph_addr <= 8'h00;
			dph_write <= 1'b0;
		end
		else if (hready)
		begin
			dph_write <= hsel && htrans == mtnhs_pkg::HTRANS_NONSEQ && hwrite;
			dph_addr <= haddr[7:0];
		end
	end

	// Register writes land in the data phase
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ctrl <= mtnhs_pkg::RST_CTRL;
			ready_setting_word <= mtnhs_pkg::RST_READY_WORD;
			axis_cmd <= mtnhs_pkg::RST_AXIS_CMD;
			finish_wait <= mtnhs_pkg::RST_FINISH;
			force_set <= 8'h00;
		end
		else
		begin
			force_set <= 8'h00;
			if (dph_write)
			begin
				case (dph_addr)
					mtnhs_pkg::OFS_CTRL: ctrl <= hwdata;
					mtnhs_pkg::OFS_READY_WORD: ready_setting_word <= hwdata[15:0];
					mtnhs_pkg::OFS_AXIS_CMD: axis_cmd <= hwdata;
					mtnhs_pkg::OFS_FINISH: finish_wait <= hwdata[7:0];
					mtnhs_pkg::OFS_START_ACC: force_set <= hwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// Read data from the address phase; unmapped reads give zero
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (haddr[7:0])
			mtnhs_pkg::OFS_CTRL: next_rdata = ctrl;
			mtnhs_pkg::OFS_READY_WORD: next_rdata = {16'h0000, ready_setting_word};
			mtnhs_pkg::OFS_STATUS:
			begin
				next_rdata[mtnhs_pkg::ST_HOST_READY] = host_ready_flag;
				next_rdata[mtnhs_pkg::ST_PROC_READY] = proc_ready_complete;
				next_rdata[mtnhs_pkg::ST_TEST_MODE] = test_mode_flag;
				next_rdata[mtnhs_pkg::ST_SYS_ERR] = system_setting_error_flag;
				next_rdata[mtnhs_pkg::ST_EDGE_ERR] = ready_edge_error;
				next_rdata[mtnhs_pkg::ST_PENDING] = pending;
				next_rdata[mtnhs_pkg::ST_MOTION_EN] = motion_enable;
			end
			mtnhs_pkg::OFS_START_ACC: next_rdata = {24'h000000, start_accepted_flag};
			mtnhs_pkg::OFS_AXIS_CMD: next_rdata = axis_cmd;
			mtnhs_pkg::OFS_FINISH: next_rdata = {16'h0000, code_output_flag, finish_wait};
			mtnhs_pkg::OFS_START_ERR: next_rdata = {24'h000000, start_accept_err};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			hrdata <= 32'h0000_0000;
		else if (hready && hsel && htrans == mtnhs_pkg::HTRANS_NONSEQ && !hwrite)
			hrdata <= next_rdata;
	end

	// Previous values for edge detection of the ready sources
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			run_prev <= 1'b0;
			word_prev <= 1'b0;
			relay_prev <= 1'b0;
			host_prev <= 1'b0;
		end
		else
		begin
			run_prev <= run_switch;
			word_prev <= ready_setting_word[0];
			relay_prev <= ctrl[mtnhs_pkg::CTRL_READY_RELAY];
			host_prev <= host_ready_flag; // RULE23
		end
	end

	// Host ready source; run_prev starts low so power-up in run counts as a rise
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			host_ready_flag <= 1'b0;
		else if (!run_switch)
			host_ready_flag <= 1'b0; // RULE13 RULE14
		else if (!ctrl[mtnhs_pkg::CTRL_ALT_MODE])
		begin
			if (!run_prev)
				host_ready_flag <= 1'b1; // RULE13
		end
		else if ((ready_setting_word[0] && !word_prev)
			|| (ctrl[mtnhs_pkg::CTRL_READY_RELAY] && !relay_prev))
			host_ready_flag <= 1'b1; // RULE14
		else if ((!ready_setting_word[0] && word_prev)
			|| (!ctrl[mtnhs_pkg::CTRL_READY_RELAY] && relay_prev))
			host_ready_flag <= 1'b0; // RULE14
	end

	assign host_rise = host_ready_flag && !host_prev; // RULE23
	assign host_fall = !host_ready_flag && host_prev; // RULE23
	// Deferred rise runs when test mode ends with ready still on
	assign do_rise = (host_rise && !test_mode_flag && axis_moving == 8'h00)
		|| (pending && !test_mode_flag && host_ready_flag); // RULE9 RULE11

	// Rise during test mode waits; a drop of ready forgets it
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			pending <= 1'b0;
		else if (!host_ready_flag || do_rise)
			pending <= 1'b0;
		else if (host_rise && test_mode_flag && axis_moving == 8'h00)
			pending <= 1'b1; // RULE11
	end

	// Sticky edge error; cleared only by reset
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			ready_edge_error <= 1'b0;
		else if (host_rise && axis_moving != 8'h00)
			ready_edge_error <= 1'b1; // RULE10
	end

	// Rise and fall processing
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			proc_ready_complete <= 1'b0;
			clear_code_storage <= 1'b0;
			program_start <= 1'b0;
			program_halt <= 1'b1;
			decel_stop_all <= 1'b0;
			real_output_points_off <= 1'b1;
		end
		else
		begin
			clear_code_storage <= do_rise; // RULE9
			program_start <= do_rise; // RULE9
			decel_stop_all <= host_fall; // RULE12
			if (do_rise)
			begin
				proc_ready_complete <= 1'b1; // RULE9
				program_halt <= 1'b0;
				real_output_points_off <= 1'b0;
			end
			else if (host_fall)
			begin
				proc_ready_complete <= 1'b0; // RULE12
				program_halt <= 1'b1; // RULE12
				real_output_points_off <= 1'b1; // RULE12
			end
		end
	end

	// Motion permission and the locked system error
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			motion_enable <= 1'b0;
			system_setting_error_flag <= 1'b0;
		end
		else
		begin
			motion_enable <= host_ready_flag && !test_mode_flag; // RULE7
			if (sys_setting_fault)
				system_setting_error_flag <= 1'b1; // RULE22
		end
	end

	assign start_allowed = motion_enable && !system_setting_error_flag; // RULE7 RULE22

	// Tool writes of parameters are gated by host ready
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			tool_write_ack <= 1'b0;
			tool_write_nak <= 1'b0;
		end
		else
		begin
			tool_write_ack <= tool_write_req && !host_ready_flag; // RULE8
			tool_write_nak <= tool_write_req && host_ready_flag; // RULE8
		end
	end

	// Speed switch option latched when an idle axis group starts
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			speed_first_pass <= 1'b0;
		else if ((start_req != 8'h00) && start_accepted_flag == 8'h00)
			speed_first_pass <= ctrl[mtnhs_pkg::CTRL_SPEED_SW]; // RULE21
	end

	// Generator g steers axis g; jog and handwheel need motion permission
	assign hw_axis = {5'h00, handwheel_enable & {3{motion_enable}}}; // RULE7 RULE18

	genvar i;
	generate
		for (i = 0; i < mtnhs_pkg::NAXIS; i++)
		begin : g_axis
			mtnhs_axis u_axis (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.gain_change_cmd(axis_cmd[mtnhs_pkg::CMD_GAIN + i]),
				.gain_change_alt_cmd(axis_cmd[mtnhs_pkg::CMD_GAIN_ALT + i]),
				.pid_select_cmd(axis_cmd[mtnhs_pkg::CMD_PID + i]),
				.closed_loop_select_cmd(axis_cmd[mtnhs_pkg::CMD_LOOP + i]),
				.amp_started(amp_started[i]),
				.amp_closed_capable(amp_closed_capable[i]),
				.amp_link_ok(amp_link_ok[i]),
				.amp_ctrl_power(amp_ctrl_power[i]),
				.finish_wait(finish_wait[mtnhs_pkg::FIN_WAIT + i]),
				.finish_ack_in(finish_ack_in[i]),
				.code_request(code_request[i]),
				.motion_enable(motion_enable),
				.start_allowed(start_allowed),
				.start_req(start_req[i]),
				.pos_complete(pos_complete[i]),
				.stop_midway(stop_midway[i]),
				.speed_zero_stop(speed_zero_stop[i]),
				.jog_fwd_cmd(jog_fwd_cmd[i]),
				.jog_rev_cmd(jog_rev_cmd[i]),
				.axis_stopped(!axis_moving[i]),
				.handwheel_on(hw_axis[i]),
				.position_change_instr(position_change_instr[i] && !position_change_instr_done),
				.force_set(force_set[i]),
				.amp_gain_sel(amp_gain_sel[2 * i +: 2]),
				.amp_pid(amp_pid[i]),
				.amp_closed_loop(amp_closed_loop[i]),
				.code_output_flag(code_output_flag[i]),
				.start_accepted_flag(start_accepted_flag[i]),
				.start_accept_err(start_accept_err[i])
			);
		end
	endgenerate

	sequence rise_ok_s;
		host_rise && !test_mode_flag && axis_moving == 8'h00;
	endsequence
	sequence rise_done_s;
		proc_ready_complete && program_start && clear_code_storage;
	endsequence
	rise_proc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rise_ok_s |=> rise_done_s) // RULE9
		else $error("ready rise not processed");
	rise_skip_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(host_rise && axis_moving != 8'h00 && !pending) |=> ready_edge_error && !program_start) // RULE10
		else $error("moving axis rise not refused");
	test_defer_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(test_mode_flag && !pending) |=> !program_start) // RULE11
		else $error("rise processed in test mode");
	fall_proc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_fall |=> !proc_ready_complete && decel_stop_all && program_halt && real_output_points_off) // RULE12
		else $error("ready fall not processed");
	stop_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!run_switch |=> !host_ready_flag) // RULE13
		else $error("ready kept with switch at stop");
	motion_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		test_mode_flag |=> !motion_enable) // RULE7
		else $error("motion enabled in test mode");
	tool_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(tool_write_req && host_ready_flag) |=> tool_write_nak && !tool_write_ack) // RULE8
		else $error("tool write accepted while ready");
	sys_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		system_setting_error_flag |=> system_setting_error_flag && !start_allowed) // RULE22
		else $error("system error lock released");
endmodule

/* tb/mtnhs_amp_model.sv */
// Servo amplifier and axis motion model facing the handshake block
`timescale 1ns/100ps
module mtnhs_amp_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] jog_cmd,
	input wire logic link_cut,
	output logic [7:0] amp_started,
	output logic [7:0] amp_closed_capable,
	output logic [7:0] amp_link_ok,
	output logic [7:0] amp_ctrl_power,
	output logic [7:0] axis_moving
);
	logic [5:0] boot_cnt;
	// 40-cycle start-up leaves room to try a loop change
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			boot_cnt <= 6'h00;
		else if (boot_cnt != 6'h28)
			boot_cnt <= boot_cnt + 6'h01;
	end
	// All loop capable and powered; link cut on demand
	assign amp_started = {8{boot_cnt == 6'h28}};
	assign amp_closed_capable = 8'hff;
	assign amp_ctrl_power = 8'hff;
	assign amp_link_ok = {8{!link_cut}};
	// Motion lags jog by a cycle, a crude deceleration
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			axis_moving <= 8'h00;
		else
			axis_moving <= jog_cmd;
	end
endmodule

/* tb/mtnhs_top_tb_top.sv */
// Self-checking bench for the motion axis handshake flags
`timescale 1ns/100ps
module mtnhs_top_tb_top;
	logic core_clk, rst_n, hsel, hwrite, hready, run_switch, test_mode_flag, sys_setting_fault, tool_write_req;
	logic link_cut, position_change_instr_done, hreadyout, hresp, host_ready_flag, proc_ready_complete;
	logic ready_edge_error, motion_enable, clear_code_storage, program_start, program_halt, decel_stop_all;
	logic real_output_points_off, tool_write_ack, tool_write_nak, system_setting_error_flag, speed_first_pass;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, handwheel_enable;
	logic [15:0] amp_gain_sel;
	logic [7:0] start_req, pos_complete, stop_midway, speed_zero_stop, axis_moving, jog_fwd_cmd, jog_rev_cmd;
	logic [7:0] position_change_instr, amp_started, amp_closed_capable, amp_link_ok, amp_ctrl_power;
	logic [7:0] finish_ack_in, code_request, start_accepted_flag, start_accept_err, amp_pid, amp_closed_loop;
	logic [7:0] code_output_flag;
	int bad_count = 0, tests_run = 0, ack_n = 0, nak_n = 0, ps_n = 0;

	// One slave: its ready is the bus ready
	assign hready = hreadyout;
	mtnhs_top i_mtnhs_top (.*);
	mtnhs_amp_model i_mtnhs_amp_model (.core_clk(core_clk), .rst_n(rst_n), .jog_cmd(jog_fwd_cmd | jog_rev_cmd),
		.link_cut(link_cut), .amp_started(amp_started), .amp_closed_capable(amp_closed_capable),
		.amp_link_ok(amp_link_ok), .amp_ctrl_power(amp_ctrl_power), .axis_moving(axis_moving));

	// 40 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Count pulses
	always @(posedge core_clk)
	begin
		if (tool_write_ack === 1'b1) ack_n++;
		if (tool_write_nak === 1'b1) nak_n++;
		if (program_start === 1'b1) ps_n++;
	end

	task tally_and_finish;
		$display("compares %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Settle just past an edge before looking
	task waitc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// One AHB-Lite word transfer; read data lands in rd
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= mtnhs_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	// One-cycle pulses on the per-axis program events
	task pulse_axis(input logic [7:0] s, input logic [7:0] p, input logic [7:0] m, input logic [7:0] z);
		@(posedge core_clk);
		start_req <= s;
		pos_complete <= p;
		stop_midway <= m;
		speed_zero_stop <= z;
		@(posedge core_clk);
		start_req <= 8'h00;
		pos_complete <= 8'h00;
		stop_midway <= 8'h00;
		speed_zero_stop <= 8'h00;
	endtask

	task tool_write;
		@(posedge core_clk);
		tool_write_req <= 1'b1;
		@(posedge core_clk);
		tool_write_req <= 1'b0;
		waitc(3);
	endtask

	// Watchdog, far past the ~190 cycles used
	initial
	begin
		#100000;
		bad_count++;
		tally_and_finish();
	end

	initial
	begin
		{hsel, hwrite, run_switch, test_mode_flag, sys_setting_fault, tool_write_req, link_cut} = '0;
		{start_req, pos_complete, stop_midway, speed_zero_stop, jog_fwd_cmd, jog_rev_cmd} = '0;
		{position_change_instr, finish_ack_in, code_request} = '0;
		{haddr, hwdata, htrans, handwheel_enable, position_change_instr_done} = '0;
		hsize = 3'h2;
		rst_n = 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		waitc(1);
		chk(program_halt, 1'b1);
		chk(real_output_points_off, 1'b1);
		bus(0, mtnhs_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h0000_0000);
		// Loop change while amplifiers still boot must be dropped
		bus(1, mtnhs_pkg::OFS_AXIS_CMD, 32'h0100_0000);
		waitc(2);
		chk(amp_closed_loop, 8'h00);
		tool_write();
		chk(ack_n, 1);
		@(posedge core_clk);
		run_switch <= 1'b1;
		waitc(3);
		chk(proc_ready_complete, 1'b1);
		chk(ps_n, 1);
		bus(0, mtnhs_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h0000_0043);
		bus(0, 8'h1c, 32'h0);
		chk(rd, 32'h0000_0000);
		tool_write();
		chk(nak_n, 1);
		// Servo options once the amplifiers are up
		waitc(40);
		chk(amp_closed_loop, 8'h00);
		bus(1, mtnhs_pkg::OFS_AXIS_CMD, 32'h0402_0101);
		waitc(2);
		chk(amp_gain_sel, {14'h0000, mtnhs_pkg::GAIN_ALT});
		chk(amp_pid, 8'h02);
		chk(amp_closed_loop, 8'h04);
		@(posedge core_clk);
		link_cut <= 1'b1;
		waitc(3);
		chk(amp_closed_loop, 8'h00);
		// Program start, completion, zero-speed hold and midway stop
		bus(1, mtnhs_pkg::OFS_CTRL, 32'h0000_0002);
		pulse_axis(8'h01, 8'h00, 8'h00, 8'h00);
		waitc(2);
		chk(start_accepted_flag, 8'h01);
		chk(speed_first_pass, 1'b1);
		pulse_axis(8'h00, 8'h01, 8'h00, 8'h00);
		waitc(3);
		chk(start_accepted_flag, 8'h00);
		pulse_axis(8'h01, 8'h00, 8'h00, 8'h00);
		pulse_axis(8'h00, 8'h00, 8'h01, 8'h01);
		waitc(3);
		chk(start_accepted_flag, 8'h01);
		pulse_axis(8'h00, 8'h00, 8'h01, 8'h00);
		waitc(3);
		chk(start_accepted_flag, 8'h00);
		// Jog both directions, then handwheel generator 2
		@(posedge core_clk);
		jog_fwd_cmd <= 8'h02;
		jog_rev_cmd <= 8'h20;
		waitc(4);
		chk(start_accepted_flag, 8'h22);
		@(posedge core_clk);
		{jog_fwd_cmd, jog_rev_cmd} <= '0;
		waitc(6);
		chk(start_accepted_flag, 8'h00);
		@(posedge core_clk);
		handwheel_enable <= 3'h4;
		position_change_instr <= 8'h40;
		waitc(3);
		chk(start_accepted_flag, 8'h44);
		@(posedge core_clk);
		handwheel_enable <= 3'h0;
		position_change_instr_done <= 1'b1;
		waitc(3);
		chk(start_accepted_flag, 8'h00);
		// Flag forced on while idle spoils the next start
		bus(1, mtnhs_pkg::OFS_START_ACC, 32'h0000_0010);
		waitc(3);
		chk(start_accepted_flag, 8'h10);
		pulse_axis(8'h10, 8'h00, 8'h00, 8'h00);
		waitc(2);
		chk(start_accept_err, 8'h10);
		bus(0, mtnhs_pkg::OFS_START_ERR, 32'h0);
		chk(rd, 32'h0000_0010);
		// Code output only on the axis under finish-wait
		bus(1, mtnhs_pkg::OFS_FINISH, 32'h0000_0001);
		@(posedge core_clk);
		code_request <= 8'h03;
		@(posedge core_clk);
		code_request <= 8'h00;
		waitc(2);
		chk(code_output_flag, 8'h01);
		@(posedge core_clk);
		finish_ack_in <= 8'h01;
		@(posedge core_clk);
		finish_ack_in <= 8'h00;
		waitc(2);
		chk(code_output_flag, 8'h00);
		// Sticky setting error refuses starts
		@(posedge core_clk);
		sys_setting_fault <= 1'b1;
		@(posedge core_clk);
		sys_setting_fault <= 1'b0;
		pulse_axis(8'h08, 8'h00, 8'h00, 8'h00);
		waitc(2);
		chk(system_setting_error_flag, 1'b1);
		chk(start_accepted_flag, 8'h00);
		// Ready fall, then a rise deferred by test mode
		@(posedge core_clk);
		run_switch <= 1'b0;
		waitc(3);
		chk({proc_ready_complete, program_halt, real_output_points_off}, 3'h3);
		@(posedge core_clk);
		test_mode_flag <= 1'b1;
		run_switch <= 1'b1;
		waitc(3);
		chk({proc_ready_complete, motion_enable}, 2'h0);
		@(posedge core_clk);
		test_mode_flag <= 1'b0;
		waitc(3);
		chk(proc_ready_complete, 1'b1);
		chk(ps_n, 2);
		// Ready rise with a moving axis is refused
		@(posedge core_clk);
		run_switch <= 1'b0;
		jog_fwd_cmd <= 8'h01;
		waitc(3);
		@(posedge core_clk);
		run_switch <= 1'b1;
		waitc(3);
		chk({ready_edge_error, proc_ready_complete}, 2'h2);
		chk(ps_n, 2);
		bus(1, mtnhs_pkg::OFS_CTRL, 32'h0000_0005);
		bus(1, mtnhs_pkg::OFS_CTRL, 32'h0000_0001);
		waitc(2);
		chk(host_ready_flag, 1'b0);
		bus(1, mtnhs_pkg::OFS_READY_WORD, 32'h0000_0001);
		waitc(2);
		chk(host_ready_flag, 1'b1);
		tally_and_finish();
	end
endmodule
